// ==== logic/ctr_pkg.sv ====
// Package of register offsets, fields, modes and reset values for the control timer
package ctr_pkg;
  localparam logic [11:0] OFF_CONTROL_A = 12'h000;
  localparam logic [11:0] OFF_CONTROL_CLEAR = 12'h004;
  localparam logic [11:0] OFF_CONTROL_SET = 12'h008;
  localparam logic [11:0] OFF_EVENT_CTRL = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_COUNT = 12'h014;
  localparam logic [11:0] OFF_PERIOD = 12'h018;
  localparam logic [11:0] OFF_PERIOD_BUF = 12'h01C;
  localparam logic [11:0] OFF_CMP0 = 12'h020;
  localparam logic [11:0] OFF_CMP1 = 12'h024;
  localparam int NCH = 2;
  localparam int CW = 16;
  // Control A fields
  localparam int CA_ENABLE = 0;
  localparam int CA_WAVE_LSB = 1;
  localparam int CA_PRESC_LSB = 4;
  localparam int CA_SYNC_LSB = 7;
  localparam int CA_DMA_ONESHOT = 9;
  localparam int CA_DITHER = 10;
  // Control set/clear fields
  localparam int CB_DIR = 0;
  localparam int CB_LOCK = 1;
  // Event control: two action bits per channel
  localparam logic [1:0] EVACT_RETRIGGER = 2'h1;
  // Status fields
  localparam int ST_PERBUFV = 0;
  localparam int ST_OVF = 1;
  localparam logic [CW-1:0] PERIOD_RESET = 16'hFFFF;
  typedef enum logic [2:0] {
    CTR_WAVE_NORMAL = 3'h0,
    CTR_WAVE_DUAL_RAMP = 3'h1,
    CTR_WAVE_DUAL_RAMP_A = 3'h2,
    CTR_WAVE_DUAL_RAMP_C = 3'h3,
    CTR_WAVE_DUAL_RAMP_CS = 3'h4
  } ctr_wave_t;
  typedef enum logic [1:0] {
    CTR_SYNC_GENERIC_CLOCK = 2'h0,
    CTR_SYNC_RESYNC = 2'h1,
    CTR_SYNC_PRESC = 2'h2
  } ctr_sync_t;
endpackage : ctr_pkg

// ==== logic/ctr_tick_if.sv ====
// Interface carrying the prescaler tick between the divider and the timer core
`timescale 1ns/1ps
interface ctr_tick_if;
  logic [2:0] ratio;
  logic restart;
  logic tick;
  modport core (output ratio, output restart, input tick);
  modport div (input ratio, input restart, output tick);
endinterface : ctr_tick_if

// ==== logic/ctr_presc.sv ====
// Prescaler divider producing a one-cycle count enable
`timescale 1ns/1ps
module ctr_presc (
  input wire logic pclk,
  input wire logic presetn,
  ctr_tick_if.div tk
);
  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } ctr_presc_st_t;
  ctr_presc_st_t s_q, s_d;
  logic [9:0] lim;
  always_comb begin
    lim = (10'h001 << tk.ratio) - 10'h001;
    s_d = s_q;
    s_d.tick = 1'b0;
    if (tk.restart) begin
      s_d.cnt = 10'h000;
    end else if (s_q.cnt >= lim) begin
      s_d.cnt = 10'h000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 10'h001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tk.tick = (tk.ratio == 3'h0) ? 1'b1 : s_q.tick;
endmodule : ctr_presc

// ==== logic/ctr_timer.sv ====
// Control timer core with APB registers, dual-ramp modes, retrigger and DMA trigger
`timescale 1ns/1ps
module ctr_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ctr_pkg::NCH-1:0] event_in,
  output logic [ctr_pkg::NCH-1:0] wave_out,
  output logic dma_ovf_req,
  input wire logic dma_ack
);
  typedef struct packed {
    logic [10:0] ctrl_a;
    logic [1:0] ctrl_b;
    logic [2*ctr_pkg::NCH-1:0] ev_ctrl;
    logic [1:0] status;
    logic [ctr_pkg::CW-1:0] count;
    logic [ctr_pkg::CW-1:0] period;
    logic [ctr_pkg::CW-1:0] period_buf;
    logic [ctr_pkg::NCH-1:0][ctr_pkg::CW-1:0] cmp;
    logic [ctr_pkg::NCH-1:0] wave;
    logic down_phase;
    logic retrig_pend;
    logic dma_req;
    logic dma_done;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [ctr_pkg::NCH-1:0] ev_s1;
    logic [ctr_pkg::NCH-1:0] ev_s2;
    logic [ctr_pkg::NCH-1:0] ev_s3;
  } ctr_st_t;
  ctr_st_t s_q, s_d;
  ctr_tick_if tk ();
  ctr_pkg::ctr_wave_t wave_mode;
  ctr_pkg::ctr_sync_t sync_sel;
  logic wr_acc, rd_acc, full_word, dual, retrig_ev, at_top, at_bot, update;
  logic [ctr_pkg::NCH-1:0] ev_rise, ch_retrig;
  logic [31:0] rmux;
  assign wave_mode = ctr_pkg::ctr_wave_t'(s_q.ctrl_a[ctr_pkg::CA_WAVE_LSB +: 3]);
  assign sync_sel = ctr_pkg::ctr_sync_t'(s_q.ctrl_a[ctr_pkg::CA_SYNC_LSB +: 2]);
  assign tk.ratio = s_q.ctrl_a[ctr_pkg::CA_PRESC_LSB +: 3];
  // Resync retrigger restarts the divider so the count phase realigns
  assign tk.restart = retrig_ev && (sync_sel == ctr_pkg::CTR_SYNC_RESYNC);
  ctr_presc u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );
  assign dual = (wave_mode != ctr_pkg::CTR_WAVE_NORMAL);
  assign wr_acc = psel && penable && pwrite && !s_q.ready;
  assign rd_acc = psel && penable && !pwrite && !s_q.ready;
  assign full_word = (pstrb == 4'hF);
  assign ev_rise = s_q.ev_s2 & ~s_q.ev_s3;
  genvar gi;
  generate
    for (gi = 0; gi < ctr_pkg::NCH; gi++) begin : g_ev
      assign ch_retrig[gi] = ev_rise[gi] &&
        (s_q.ev_ctrl[2*gi +: 2] == ctr_pkg::EVACT_RETRIGGER);
    end
  endgenerate
  assign retrig_ev = |ch_retrig;
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (paddr)
      ctr_pkg::OFF_CONTROL_A: rmux = {21'h0, s_q.ctrl_a};
      ctr_pkg::OFF_CONTROL_CLEAR: rmux = {30'h0, s_q.ctrl_b};
      ctr_pkg::OFF_CONTROL_SET: rmux = {30'h0, s_q.ctrl_b};
      ctr_pkg::OFF_EVENT_CTRL: rmux = {28'h0, s_q.ev_ctrl};
      ctr_pkg::OFF_STATUS: rmux = {30'h0, s_q.status};
      ctr_pkg::OFF_COUNT: rmux = {16'h0, s_q.count};
      ctr_pkg::OFF_PERIOD: rmux = {16'h0, s_q.period};
      ctr_pkg::OFF_PERIOD_BUF: rmux = {16'h0, s_q.period_buf};
      ctr_pkg::OFF_CMP0: rmux = {16'h0, s_q.cmp[0]};
      ctr_pkg::OFF_CMP1: rmux = {16'h0, s_q.cmp[1]};
      default: rmux = 32'h0000_0000;
    endcase
  end
  // Top and bottom of the current counting cycle
  assign at_top = s_q.count >= s_q.period;
  assign at_bot = s_q.count == 16'h0000;
  always_comb begin
    s_d = s_q;
    update = 1'b0;
    s_d.ev_s1 = event_in;
    s_d.ev_s2 = s_q.ev_s1;
    s_d.ev_s3 = s_q.ev_s2;
    s_d.ready = rd_acc || wr_acc;
    s_d.err = 1'b0;
    if (rd_acc) begin
      s_d.rdata = rmux;
    end
    if (wr_acc) begin
      unique case (paddr)
        ctr_pkg::OFF_CONTROL_A: s_d.ctrl_a = pwdata[10:0];
        ctr_pkg::OFF_CONTROL_CLEAR: s_d.ctrl_b = s_q.ctrl_b & ~pwdata[1:0];
        ctr_pkg::OFF_CONTROL_SET: s_d.ctrl_b = s_q.ctrl_b | pwdata[1:0];
        ctr_pkg::OFF_EVENT_CTRL: s_d.ev_ctrl = pwdata[3:0];
        ctr_pkg::OFF_STATUS: begin
          if (full_word) begin
            s_d.status = s_q.status & ~pwdata[1:0];
          end else begin
            s_d.err = 1'b1;
          end
        end
        ctr_pkg::OFF_COUNT: s_d.count = pwdata[15:0];
        ctr_pkg::OFF_PERIOD: s_d.period = pwdata[15:0];
        ctr_pkg::OFF_PERIOD_BUF: begin
          s_d.period_buf = pwdata[15:0];
          s_d.status[ctr_pkg::ST_PERBUFV] = 1'b1;
        end
        ctr_pkg::OFF_CMP0: s_d.cmp[0] = pwdata[15:0];
        ctr_pkg::OFF_CMP1: s_d.cmp[1] = pwdata[15:0];
        default: s_d.err = 1'b1;
      endcase
    end
    if (s_q.ctrl_a[ctr_pkg::CA_ENABLE]) begin
      // Retrigger waits for a prescaler tick in every sync mode
      if (retrig_ev) begin
        s_d.retrig_pend = 1'b1;
      end
      if (tk.tick) begin
        if (s_q.retrig_pend || retrig_ev) begin
          // Retrigger restarts every mode at cycle start
          s_d.retrig_pend = 1'b0;
          s_d.down_phase = 1'b0;
          s_d.count = s_q.ctrl_b[ctr_pkg::CB_DIR] && !dual ? s_q.period : 16'h0000;
          // Compare restarts from a clean level
          for (int i = 0; i < ctr_pkg::NCH; i++) begin
            s_d.wave[i] = 1'b1;
          end
          update = 1'b1;
        end else if (dual) begin
          // Dual ramp counts up then down regardless of direction bit
          if (!s_q.down_phase) begin
            if (at_top) begin
              s_d.down_phase = 1'b1;
              s_d.count = s_q.count - 16'h0001;
            end else begin
              s_d.count = s_q.count + 16'h0001;
            end
          end else if (at_bot) begin
            s_d.down_phase = 1'b0;
            s_d.count = s_q.count + 16'h0001;
            update = 1'b1;
          end else begin
            s_d.count = s_q.count - 16'h0001;
          end
        end else if (s_q.ctrl_b[ctr_pkg::CB_DIR]) begin
          s_d.count = at_bot ? s_q.period : s_q.count - 16'h0001;
          update = at_bot;
        end else begin
          s_d.count = at_top ? 16'h0000 : s_q.count + 16'h0001;
          update = at_top;
        end
        for (int i = 0; i < ctr_pkg::NCH; i++) begin
          if (!(s_q.retrig_pend || retrig_ev)) begin
            s_d.wave[i] = s_d.count < s_q.cmp[i];
          end
        end
      end
    end
    // Ack clears first so an overflow in the same cycle still raises the request
    if (dma_ack) begin
      s_d.dma_req = 1'b0;
    end
    if (update) begin
      s_d.status[ctr_pkg::ST_OVF] = 1'b1;
      // Lock holds period in any direction
      if (!s_q.ctrl_b[ctr_pkg::CB_LOCK] && s_q.status[ctr_pkg::ST_PERBUFV]) begin
        s_d.period = s_q.period_buf;
        // A buffer write in the same cycle keeps its valid flag
        s_d.status[ctr_pkg::ST_PERBUFV] = wr_acc && (paddr == ctr_pkg::OFF_PERIOD_BUF);
      end
      // Overflow DMA trigger, one-shot fires once until its enable bit is cleared
      if (!(s_q.ctrl_a[ctr_pkg::CA_DMA_ONESHOT] && s_q.dma_done)) begin
        s_d.dma_req = 1'b1;
        s_d.dma_done = s_q.ctrl_a[ctr_pkg::CA_DMA_ONESHOT];
      end
    end
    if (!s_q.ctrl_a[ctr_pkg::CA_DMA_ONESHOT]) begin
      s_d.dma_done = 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.period <= ctr_pkg::PERIOD_RESET;
    end else begin
      s_q <= s_d;
    end
  end
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign wave_out = s_q.wave;
  assign dma_ovf_req = s_q.dma_req;
  // Locked period never changes on update
  a_lock_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.ctrl_b[ctr_pkg::CB_LOCK] && !wr_acc) |=> $stable(s_q.period))
    else $error("period changed while locked");
  a_buf_copy: assert property (@(posedge pclk) disable iff (!presetn)
    (update && !s_q.ctrl_b[ctr_pkg::CB_LOCK] && s_q.status[ctr_pkg::ST_PERBUFV])
    |=> (s_q.period == $past(s_q.period_buf)))
    else $error("period not loaded from buffer");
  a_retrig_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.ctrl_a[ctr_pkg::CA_ENABLE] && tk.tick && retrig_ev && dual)
    |=> (s_q.count == 16'h0000 && !s_q.down_phase))
    else $error("retrigger did not restart counter");
  a_status_narrow: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == ctr_pkg::OFF_STATUS && !full_word)
    |=> (pslverr && pready && $stable(s_q.status[ctr_pkg::ST_PERBUFV])))
    else $error("narrow status write accepted");
  a_dma_trigger: assert property (@(posedge pclk) disable iff (!presetn)
    (update && !s_q.ctrl_a[ctr_pkg::CA_DMA_ONESHOT] && !dma_ack) |=> dma_ovf_req)
    else $error("overflow DMA request missing");
  a_dma_oneshot: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.ctrl_a[ctr_pkg::CA_DMA_ONESHOT] && s_q.dma_done && !dma_ovf_req)
    |=> !dma_ovf_req)
    else $error("one-shot DMA retriggered");
  a_dir_down: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.ctrl_a[ctr_pkg::CA_ENABLE] && tk.tick && !dual && s_q.ctrl_b[ctr_pkg::CB_DIR]
     && !retrig_ev && !s_q.retrig_pend && !at_bot && !wr_acc)
    |=> (s_q.count == $past(s_q.count) - 16'h0001))
    else $error("down count wrong");
  a_presc_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.ctrl_a[ctr_pkg::CA_ENABLE] && retrig_ev && !tk.tick) |=> s_q.retrig_pend)
    else $error("retrigger lost before tick");
  a_dual_turn: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.ctrl_a[ctr_pkg::CA_ENABLE] && tk.tick && dual && !s_q.down_phase && at_top
     && !retrig_ev && !s_q.retrig_pend && !wr_acc) |=> s_q.down_phase)
    else $error("dual ramp did not turn");
endmodule : ctr_timer

// ==== bench/ctr_far_model.sv ====
// Event source and DMA acknowledger at the far side of the control timer
`timescale 1ns/1ps
module ctr_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dma_ovf_req,
  input wire logic [1:0] fire,
  input wire logic [3:0] ack_delay,
  output logic [1:0] event_in,
  output logic dma_ack,
  output int acks
);
  logic [3:0] wait_q;
  always @(posedge pclk) begin
    event_in <= fire;
  end
  // Ack after a set wait, so slow answers are exercised too
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_ack <= 1'b0;
      wait_q <= 4'h0;
      acks <= 0;
    end else if (dma_ack) begin
      dma_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (dma_ovf_req) begin
      if (wait_q >= ack_delay) begin
        dma_ack <= 1'b1;
        acks <= acks + 1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : ctr_far_model

// ==== bench/testbench.sv ====
// Self-checking bench for the control timer over APB
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] ST = ctr_pkg::OFF_STATUS;
  localparam logic [11:0] CA = ctr_pkg::OFF_CONTROL_A;
  localparam logic [11:0] PV = ctr_pkg::OFF_PERIOD;
  localparam logic [11:0] PB = ctr_pkg::OFF_PERIOD_BUF;
  localparam logic [11:0] CNT = ctr_pkg::OFF_COUNT;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] event_in;
  logic [1:0] wave_out;
  logic dma_ovf_req;
  logic dma_ack;
  logic [1:0] fire = 2'h0;
  logic [3:0] ack_delay = 4'h0;
  int acks;
  int a0;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  always #2 pclk = ~pclk;
  ctr_timer ctr_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_in(event_in), .wave_out(wave_out),
    .dma_ovf_req(dma_ovf_req), .dma_ack(dma_ack));
  ctr_far_model ctr_far_model_i (.pclk(pclk), .presetn(presetn), .dma_ovf_req(dma_ovf_req),
    .fire(fire), .ack_delay(ack_delay), .event_in(event_in), .dma_ack(dma_ack), .acks(acks));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Hang guard well above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hF);
    cmp(nm, exp, rd);
  endtask : rdc
  // Poll until the buffered period has been taken over
  task automatic wait_upd;
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 100) begin
      apb(1'b0, ST, 32'h0, 4'hF);
      n++;
    end
  endtask : wait_upd
  function automatic logic near(input logic [15:0] x, input logic [15:0] y);
    logic [15:0] d;
    d = x - y;
    return d != 16'h0 && d < 16'h10;
  endfunction : near
  // Two steps are read so one wrap at the period cannot spoil the check
  task automatic dirchk(input logic down);
    logic [15:0] c [3];
    logic ok;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, CNT, 32'h0, 4'hF);
      c[i] = rd[15:0];
    end
    ok = down ? (near(c[0], c[1]) || near(c[1], c[2])) : (near(c[1], c[0]) || near(c[2], c[1]));
    cmp("direction", 32'h1, {31'h0, ok});
  endtask : dirchk
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("period reset", PV, 32'h0000FFFF);
    rdc("status reset", ST, 32'h0);
    apb(1'b1, 12'hFF0, 32'h0, 4'hF);
    cmp("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, ST, 32'h3, 4'h1);
    cmp("status byte error", 32'h1, {31'h0, err});
    apb(1'b1, ST, 32'h3, 4'hF);
    cmp("status word error", 32'h0, {31'h0, err});
    $display("test registers done");
    wr(PV, 32'h40);
    wr(ctr_pkg::OFF_CMP0, 32'h20);
    // Dither bit left clear while the period update is tested
    wr(CA, 32'h1);
    wr(PB, 32'h80);
    apb(1'b0, ST, 32'h0, 4'hF);
    cmp("buffer valid", 32'h1, rd & 32'h1);
    wait_upd();
    rdc("period updated", PV, 32'h80);
    dirchk(1'b0);
    $display("test period update done");
    wr(ctr_pkg::OFF_CONTROL_SET, 32'h2);
    wr(PB, 32'h60);
    repeat (300) @(posedge pclk);
    rdc("period locked up", PV, 32'h80);
    wr(ctr_pkg::OFF_CONTROL_SET, 32'h1);
    dirchk(1'b1);
    repeat (300) @(posedge pclk);
    rdc("period locked down", PV, 32'h80);
    wr(ctr_pkg::OFF_CONTROL_CLEAR, 32'h2);
    wait_upd();
    rdc("period unlocked", PV, 32'h60);
    wr(ctr_pkg::OFF_CONTROL_CLEAR, 32'h1);
    $display("test lock done");
    a0 = acks;
    repeat (400) @(posedge pclk);
    cmp("dma repeats", 32'h1, {31'h0, acks - a0 > 1});
    ack_delay <= 4'h9;
    wr(CA, 32'h201);
    repeat (400) @(posedge pclk);
    a0 = acks;
    repeat (400) @(posedge pclk);
    cmp("dma one shot", 32'h0, acks - a0);
    wr(CA, 32'h1);
    $display("test dma done");
    wr(ctr_pkg::OFF_EVENT_CTRL, {30'h0, ctr_pkg::EVACT_RETRIGGER});
    for (int m = 1; m < 6; m++) begin
      // Prescaled dual ramp uses prescaler sync
      wr(CA, (m == 5) ? 32'h119 : {28'h0, 3'(m), 1'b1});
      rd = 32'h0;
      while (rd[15:0] < 16'h40) begin
        apb(1'b0, CNT, 32'h0, 4'hF);
      end
      cmp("wave above compare", 32'h0, {31'h0, wave_out[0]});
      fire <= 2'h1;
      repeat (8) @(posedge pclk);
      fire <= 2'h0;
      apb(1'b0, CNT, 32'h0, 4'hF);
      cmp("count after retrigger", 32'h1, {31'h0, rd[15:0] < 16'h20});
      cmp("wave after retrigger", 32'h1, {31'h0, wave_out[0]});
    end
    $display("test retrigger done");
    test_done();
  end
endmodule : testbench
